/* File: hw/gtw_pkg.sv */
// Purpose: Shared constants and types for the gauge two-wire slave port
// Assumes: 50 MHz system clock, byte-wide register space behind the serial port
// Notes: Map holds live, control, user and identification windows

package gtw_pkg;

  // Clock and bus-low sleep timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam real BUS_LOW_SLEEP_S = 2.2; // Longest allowed bus-low time before sleep, seconds
  // Sync stages add clocks before the count starts and the flag stage after it ends, so they come off the budget
  localparam int unsigned SLEEP_LAT_CYC = 3;
  localparam int unsigned BUS_LOW_SLEEP_CYC = int'($floor(BUS_LOW_SLEEP_S * real'(CLK_HZ))) - SLEEP_LAT_CYC;

  // Widths
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BYTE_W = 8;

  // Register windows seen over the serial port
  localparam logic [7:0] LIVE_BASE = 8'h00;
  localparam int unsigned LIVE_BYTES = 16;
  localparam logic [7:0] CTRL_BASE = 8'h10;
  localparam int unsigned CTRL_BYTES = 16;
  localparam logic [7:0] USER_BASE = 8'h20;
  localparam int unsigned USER_BYTES = 16;
  localparam logic [7:0] ID_BASE = 8'h30;
  localparam int unsigned ID_BYTES = 8;
  localparam int unsigned WR_BYTES = CTRL_BYTES + USER_BYTES;

  // Control window fields
  localparam logic [4:0] CTRL_SLAVE_ADDR_IDX = 5'h00;
  localparam logic [4:0] CTRL_PIO_IDX = 5'h01;
  localparam int unsigned PIO_DRIVE_BIT = 0;

  // Reset and fill values
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h34;
  localparam logic [7:0] EMPTY_BYTE = 8'hff;

  // Identification fields (arbitrary neutral values)
  localparam logic [7:0] ID_FAMILY_DEF = 8'h5a;
  localparam logic [47:0] ID_SERIAL_DEF = 48'h0123_4567_89ab;
  localparam logic [7:0] ID_CHECK_DEF = 8'hc3;

  // Serial protocol phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_ACK = 3'b010,
    PH_WRITE = 3'b011,
    PH_READ = 3'b100,
    PH_RDACK = 3'b101
  } gtw_phase_t;

  // Raw pin levels carried together into the synchroniser
  typedef struct packed {
    logic programmable_io_pin;
    logic scl;
    logic sda;
  } gtw_pins_t;

endpackage : gtw_pkg

/* File: hw/gtw_pin_sync.sv */
// Purpose: Two-flop synchroniser for the serial and general-purpose pins
// Assumes: Pins are asynchronous to clock
// Notes: Only the second stage leaves this module

`timescale 1ns/1ps

module gtw_pin_sync
  import gtw_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pins in, synchronised levels out
  input wire gtw_pins_t pinsRaw,
  output gtw_pins_t pinsSync
);

  typedef struct packed {
    gtw_pins_t stage1;
    gtw_pins_t stage2;
  } gtw_sync_state_t;

  // Idle bus reads high, so reset to high keeps false edges away
  localparam gtw_sync_state_t SYNC_RST = '{stage1: 3'b111, stage2: 3'b111};

  gtw_sync_state_t syncQ;
  gtw_sync_state_t syncD;

  // Stage one feeds stage two only
  always_comb begin
    syncD = syncQ;
    syncD.stage1 = pinsRaw;
    syncD.stage2 = syncQ.stage1;
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      syncQ <= SYNC_RST;
    end else begin
      syncQ <= syncD;
    end
  end

  assign pinsSync = syncQ.stage2;

endmodule : gtw_pin_sync

/* File: hw/gtw_slave_port.sv */
// Purpose: Two-wire serial slave port of a battery fuel gauge
// Assumes: Bus master obeys timing; pins synchronised on the 50 MHz clock
// Notes: Byte pointer auto-increments; first written byte after address sets it
//
// Contract
// [R1] Answer programmable 7-bit address, 128 devices
// [R2] Host reads and writes status, control, data; live window bytes are read-only here, writes to them are dropped
// [R3] Sixteen user bytes readable and writable
// [R4] Optional 64-bit family, serial, check identifier
// [R5] Data line only pulled low, else released
// [R6] Clock line is input only, never stretched
// [R7] General pin: input monitor or open-drain output
// [R8] Master holds bus low past interval for sleep
// [R9] Master keeps normal low periods under interval
// [R10] Bus low both lines sleeps within 2.2 s
// [R11] Acknowledge only own address, else stay released

`timescale 1ns/1ps

module gtw_slave_port
  import gtw_pkg::*;
#(
  parameter int unsigned SLEEP_CYCLES = BUS_LOW_SLEEP_CYC,
  parameter logic [6:0] RESET_SLAVE_ADDR = DEF_SLAVE_ADDR,
  parameter bit ID_FITTED = 1'b1,
  parameter logic [7:0] ID_FAMILY = ID_FAMILY_DEF,
  parameter logic [47:0] ID_SERIAL = ID_SERIAL_DEF,
  parameter logic [7:0] ID_CHECK = ID_CHECK_DEF
)(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial data pin, open drain
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOutEnN,
  // Serial clock pin, input only
  input wire logic sclIn,
  // General-purpose pin, open drain
  input wire logic pioIn,
  output logic pioOut,
  output logic pioOutEnN,
  // Measurement side
  input wire logic [LIVE_BYTES-1:0][7:0] liveRegs,
  output logic [WR_BYTES-1:0][7:0] storeRegs,
  output logic pioLevel,
  output logic busLowSleep
);

  localparam int unsigned SLEEP_W = $clog2(SLEEP_CYCLES + 1);

  // Elaboration checks on parameters the logic cannot serve
  if (SLEEP_CYCLES < 1) begin : gen_bad_sleep
    $error("SLEEP_CYCLES must be at least one");
  end

  typedef struct packed {
    gtw_phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic ptrPending;
    logic isRead;
    logic ackDrive;
    logic masterAck;
    logic sdaLow;
    logic sclPrev;
    logic sdaPrev;
    logic [SLEEP_W-1:0] lowCnt;
    logic sleepFlag;
    logic [WR_BYTES-1:0][7:0] mem;
  } gtw_port_state_t;

  localparam gtw_port_state_t PORT_RST = '{
    phase: PH_IDLE, bitCnt: 3'h0, shift: 8'h00, ptr: 8'h00, ptrPending: 1'b0,
    isRead: 1'b0, ackDrive: 1'b0, masterAck: 1'b0, sdaLow: 1'b0,
    sclPrev: 1'b1, sdaPrev: 1'b1, lowCnt: '0, sleepFlag: 1'b0,
    mem: {{(WR_BYTES - 1){8'h00}}, {1'b0, RESET_SLAVE_ADDR}}
  };

  gtw_port_state_t q;
  gtw_port_state_t d;
  gtw_pins_t pinsSync;
  logic sda;
  logic scl;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  logic [7:0] rdByte;
  logic [7:0] rxByte;
  logic [4:0] memIdx;
  logic inWrWin;
  logic [ID_BYTES-1:0][7:0] idBytes;

  // Pins cross into the clock domain before anything looks at them
  gtw_pin_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pinsRaw({pioIn, sclIn, sdaIn}), // Same order as the pin struct
    .pinsSync(pinsSync)
  );

  // Bus conditions from synchronised levels
  assign sda = pinsSync.sda;
  assign scl = pinsSync.scl;
  assign startCond = scl & q.sclPrev & q.sdaPrev & ~sda;
  assign stopCond = scl & q.sclPrev & ~q.sdaPrev & sda;
  assign sclRise = scl & ~q.sclPrev;
  assign sclFall = ~scl & q.sclPrev;
  assign rxByte = {q.shift[6:0], sda};

  // Byte 0 is family, bytes 1..6 serial, byte 7 check code
  assign idBytes = {ID_CHECK, ID_SERIAL, ID_FAMILY}; // [R4]

  // Read decode of the byte at the pointer
  assign inWrWin = (q.ptr >= CTRL_BASE) && (q.ptr < ID_BASE);
  assign memIdx = 5'(q.ptr - CTRL_BASE);
  always_comb begin
    if (q.ptr < CTRL_BASE) begin
      rdByte = liveRegs[q.ptr[3:0]]; // [R2]
    end else if (inWrWin) begin
      rdByte = q.mem[memIdx]; // [R2] [R3]
    end else if ((q.ptr < ID_BASE + 8'(ID_BYTES)) && ID_FITTED) begin
      rdByte = idBytes[q.ptr[2:0]]; // [R4]
    end else begin
      rdByte = EMPTY_BYTE;
    end
  end

  // Protocol engine and bus-low timer
  always_comb begin
    d = q;
    d.sclPrev = scl;
    d.sdaPrev = sda;
    // Bus-low sleep detection, ended by either line going high
    if (~sda & ~scl) begin
      if (q.lowCnt != SLEEP_W'(SLEEP_CYCLES - 1)) begin
        d.lowCnt = q.lowCnt + 1'b1; // [R10]
      end else begin
        d.sleepFlag = 1'b1; // [R10]
      end
    end else begin
      d.lowCnt = '0;
      d.sleepFlag = 1'b0;
    end
    if (q.sleepFlag) begin
      // A sleeping bus abandons any transfer
      d.phase = PH_IDLE;
      d.sdaLow = 1'b0;
    end else if (startCond) begin
      d.phase = PH_ADDR;
      d.bitCnt = 3'h0;
      d.sdaLow = 1'b0;
    end else if (stopCond) begin
      d.phase = PH_IDLE;
      d.sdaLow = 1'b0;
    end else begin
      unique case (q.phase)
        PH_IDLE: begin
          d.sdaLow = 1'b0;
        end
        PH_ADDR: begin
          if (sclRise) begin
            d.shift = rxByte;
            d.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == 3'h7) begin
              // Seven address bits then direction bit
              if (q.shift[6:0] == q.mem[CTRL_SLAVE_ADDR_IDX][6:0]) begin // [R1] [R11]
                d.phase = PH_ACK;
                d.isRead = sda;
                d.ptrPending = ~sda;
                d.ackDrive = 1'b0;
              end else begin
                d.phase = PH_IDLE; // [R11]
              end
            end
          end
        end
        PH_ACK: begin
          // First fall pulls low for the ack bit, second fall ends it
          if (sclFall) begin
            if (!q.ackDrive) begin
              d.ackDrive = 1'b1;
              d.sdaLow = 1'b1;
            end else begin
              d.ackDrive = 1'b0;
              d.bitCnt = 3'h0;
              if (q.isRead) begin
                d.phase = PH_READ;
                d.shift = rdByte;
                d.ptr = q.ptr + 8'h01;
                d.sdaLow = ~rdByte[7]; // [R5]
              end else begin
                d.phase = PH_WRITE;
                d.sdaLow = 1'b0;
              end
            end
          end
        end
        PH_WRITE: begin
          if (sclRise) begin
            d.shift = rxByte;
            d.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == 3'h7) begin
              d.phase = PH_ACK;
              d.ackDrive = 1'b0;
              if (q.ptrPending) begin
                d.ptr = rxByte;
                d.ptrPending = 1'b0;
              end else begin
                if (inWrWin) begin
                  d.mem[memIdx] = rxByte; // [R2] [R3]
                end
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        PH_READ: begin
          // Data changes only while the master holds the clock low
          if (sclFall) begin
            if (q.bitCnt == 3'h7) begin
              d.phase = PH_RDACK;
              d.sdaLow = 1'b0;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.bitCnt = q.bitCnt + 3'h1;
              d.sdaLow = ~q.shift[6]; // [R5]
            end
          end
        end
        PH_RDACK: begin
          if (sclRise) begin
            d.masterAck = ~sda;
          end
          if (sclFall) begin
            d.bitCnt = 3'h0;
            if (q.masterAck) begin
              d.phase = PH_READ;
              d.shift = rdByte;
              d.ptr = q.ptr + 8'h01;
              d.sdaLow = ~rdByte[7]; // [R5]
            end else begin
              d.phase = PH_IDLE;
            end
          end
        end
        default: begin
          d.phase = PH_IDLE;
          d.sdaLow = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= PORT_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs; clock pin has no driver at all, so it is never stretched
  assign sdaOut = 1'b0; // [R5] [R6]
  assign sdaOutEnN = ~q.sdaLow; // [R5]
  assign pioOut = 1'b0; // [R7]
  assign pioOutEnN = ~q.mem[CTRL_PIO_IDX][PIO_DRIVE_BIT]; // [R7]
  assign pioLevel = pinsSync.programmable_io_pin; // [R7]
  assign storeRegs = q.mem;
  assign busLowSleep = q.sleepFlag; // [R8] [R9]

endmodule : gtw_slave_port

/* File: sim/gtw_asserts.sv */
// Purpose: Port checks for the slave port
// Assumes: Master phases of 10 clocks
// Notes: Bound below
`timescale 1ns/1ps
module gtw_asserts
  import gtw_pkg::*;
#(parameter int unsigned SLEEP_CYCLES = 50)(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pins
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOutEnN,
  input wire logic sclIn,
  input wire logic pioIn,
  input wire logic pioOut,
  input wire logic pioOutEnN,
  // Core side
  input wire logic [WR_BYTES-1:0][7:0] storeRegs,
  input wire logic pioLevel,
  input wire logic busLowSleep
);
  int unsigned lowCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Raw bus-low time, so the sync delay sits in the bound
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) lowCnt <= 0;
    else lowCnt <= (sdaIn | sclIn) ? 0 : lowCnt + 1;
  end
  sda_low_only_a: assert property (sdaOut == 1'b0)
    else $error("data driven high");
  pio_low_only_a: assert property (pioOut == 1'b0)
    else $error("pin driven high");
  // Pin drive moves only when a written byte lands, in clock high
  pio_drive_a: assert property ($changed(pioOutEnN) |-> sclIn && $past(sclIn, 2) && pioOutEnN == !storeRegs[1][0])
    else $error("pin drive wrong");
  pio_sense_a: assert property ($stable(pioIn) [*5] |-> pioLevel == pioIn)
    else $error("pin level wrong");
  // Data moves only in clock low, never holding the clock up
  sda_change_a: assert property ($changed(sdaOutEnN) |-> !sclIn && $past(!sclIn, 2))
    else $error("data moved in clock high");
  sleep_entry_a: assert property ($rose(busLowSleep) |-> lowCnt >= SLEEP_CYCLES)
    else $error("sleep too early");
  sleep_bound_a: assert property (lowCnt >= SLEEP_CYCLES + 6 |-> busLowSleep)
    else $error("sleep too late");
  sleep_exit_a: assert property ((sdaIn | sclIn) [*6] |-> !busLowSleep)
    else $error("sleep not left");
  cover property ($rose(busLowSleep));
  cover property ($fell(sdaOutEnN));
  cover property ($fell(pioOutEnN));
endmodule : gtw_asserts

bind gtw_slave_port gtw_asserts #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk (.*);

/* File: sim/gtw_master.sv */
// Purpose: Host bus master model
// Assumes: Wired-and lines, pull-ups
// Notes: Phases far below sleep time
`timescale 1ns/1ps
module gtw_master (
  // Clock and data level
  input wire logic clock,
  input wire logic sda,
  // Enables, low pulls the line
  output logic sclEnN,
  output logic sdaEnN
);
  initial begin
    sclEnN = 1'b1;
    sdaEnN = 1'b1;
  end
  // Short phases keep normal lows clear of sleep
  task automatic hp();
    repeat (10) @(negedge clock);
  endtask : hp
  // Data moves a little after the fall so it never looks like a start
  task automatic bitx(input logic b, output logic r);
    repeat (2) @(negedge clock);
    sdaEnN = b;
    hp();
    sclEnN = 1'b1;
    hp();
    r = sda;
    sclEnN = 1'b0;
  endtask : bitx
  task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] r, output logic ao);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(ai, ao);
  endtask : xfer
  task automatic start();
    hp();
    sdaEnN = 1'b1;
    hp();
    sclEnN = 1'b1;
    hp();
    sdaEnN = 1'b0;
    hp();
    sclEnN = 1'b0;
  endtask : start
  task automatic stop();
    hp();
    sdaEnN = 1'b0;
    hp();
    sclEnN = 1'b1;
    hp();
    sdaEnN = 1'b1;
    hp();
  endtask : stop
  // Both lines low for n clocks
  task automatic busLow(input int n);
    sdaEnN = 1'b0;
    sclEnN = 1'b0;
    repeat (n) @(negedge clock);
    sclEnN = 1'b1;
    sdaEnN = 1'b1;
  endtask : busLow
endmodule : gtw_master

/* File: sim/tb_gauge_two_wire_slave_port.sv */
// Purpose: Scenario bench for the slave port
// Assumes: Sleep count cut to 50
// Notes: Pull-ups on all lines
`timescale 1ns/1ps
module tb_gauge_two_wire_slave_port
  import gtw_pkg::*;
();
  localparam int unsigned SLP = 50;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic pioExt = 1'b1;
  logic sdaOutEnN, pioOutEnN, sclEnN, sdaEnN, pioLevel, busLowSleep, ak;
  logic [LIVE_BYTES-1:0][7:0] liveRegs;
  logic [WR_BYTES-1:0][7:0] storeRegs;
  logic [7:0] rb;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  initial for (int i = 0; i < LIVE_BYTES; i++) liveRegs[i] = 8'h80 + 8'(i);
  // Wired-and lines; the master alone owns the clock
  wire sdaIn = sdaEnN & sdaOutEnN;
  wire pioIn = pioExt & pioOutEnN;
  gtw_slave_port #(.SLEEP_CYCLES(SLP)) uut (.clock(clock), .sys_rst(sys_rst), .sdaIn(sdaIn), .sdaOut(),
    .sdaOutEnN(sdaOutEnN), .sclIn(sclEnN), .pioIn(pioIn), .pioOut(), .pioOutEnN(pioOutEnN),
    .liveRegs(liveRegs), .storeRegs(storeRegs), .pioLevel(pioLevel), .busLowSleep(busLowSleep));
  gtw_master hm (.clock(clock), .sda(sdaIn), .sclEnN(sclEnN), .sdaEnN(sdaEnN));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %0t: %h not %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic adr(input logic [6:0] a, input logic rw);
    hm.start();
    hm.xfer({a, rw}, 1'b1, rb, ak);
  endtask : adr
  // Pointer then one data byte
  task automatic wr1(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    adr(a, 1'b0);
    chk1(ak, 1'b0);
    hm.xfer(p, 1'b1, rb, ak);
    hm.xfer(d, 1'b1, rb, ak);
    chk1(ak, 1'b0);
    hm.stop();
  endtask : wr1
  // Pointer, repeated start, read address
  task automatic rdp(input logic [7:0] p);
    adr(7'h34, 1'b0);
    hm.xfer(p, 1'b1, rb, ak);
    adr(7'h34, 1'b1);
  endtask : rdp
  task automatic rd(input logic last, input logic [7:0] e);
    hm.xfer(8'hff, last, rb, ak);
    chk8(rb, e);
  endtask : rd
  task automatic s_reset();
    chk8(storeRegs[0], {1'b0, DEF_SLAVE_ADDR});
    chk1(sdaOutEnN, 1'b1);
    chk1(pioOutEnN, 1'b1);
  endtask : s_reset
  // User area edges, read on through the identifier
  task automatic s_user();
    logic [63:0] idv = {ID_CHECK_DEF, ID_SERIAL_DEF, ID_FAMILY_DEF};
    wr1(7'h34, 8'h20, 8'ha5);
    chk8(storeRegs[16], 8'ha5);
    wr1(7'h34, 8'h2f, 8'h3c);
    rdp(8'h2f);
    rd(1'b0, 8'h3c);
    for (int i = 0; i < 8; i++) rd(1'b0, idv[8*i+:8]);
    rd(1'b1, 8'hff);
    hm.stop();
    // Live bytes are read-only: the write is acked but must not land
    wr1(7'h34, 8'h0f, 8'h00);
    rdp(8'h0f);
    rd(1'b1, 8'h8f);
    hm.stop();
  endtask : s_user
  // Foreign address ignored; top address then restored
  task automatic s_addr();
    adr(7'h35, 1'b0);
    chk1(ak, 1'b1);
    hm.xfer(8'hff, 1'b1, rb, ak);
    chk8(rb, 8'hff);
    hm.stop();
    wr1(7'h34, 8'h10, 8'h7f);
    adr(7'h34, 1'b0);
    chk1(ak, 1'b1);
    hm.stop();
    wr1(7'h7f, 8'h10, 8'h34);
    chk8(storeRegs[0], {1'b0, DEF_SLAVE_ADDR});
  endtask : s_addr
  // Short low ignored; long low sleeps, then wakes
  task automatic s_sleep();
    int n;
    hm.busLow(SLP - 20);
    chk1(busLowSleep, 1'b0);
    repeat (20) @(negedge clock);
    hm.busLow(SLP + 10);
    chk1(busLowSleep, 1'b1);
    for (n = 0; n < 10 && busLowSleep; n++) @(negedge clock);
    chk1(busLowSleep, 1'b0);
  endtask : s_sleep
  // Drive the pin low, then sense an outside low
  task automatic s_pio();
    wr1(7'h34, 8'h11, 8'h01);
    chk1(pioOutEnN, 1'b0);
    chk1(pioLevel, 1'b0);
    wr1(7'h34, 8'h11, 8'h00);
    pioExt = 1'b0;
    repeat (6) @(negedge clock);
    chk1(pioOutEnN, 1'b1);
    chk1(pioLevel, 1'b0);
    pioExt = 1'b1;
  endtask : s_pio
  task automatic results();
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    s_reset();
    s_user();
    s_addr();
    s_sleep();
    s_pio();
    results();
  end
endmodule : tb_gauge_two_wire_slave_port
